// ### tb/serial_flash_command_frontend_bench.sv
// Purpose: Self-checking bench for the serial flash command front end.
// Assumes: Events are matched in order against notes made by the driver.
// Notes:   Consumer stalls at random, so the two-entry buffer is exercised.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_command_frontend_bench;
	logic clk = 1'b0, reset_n = 1'b0, evt_ready = 1'b0, busy = 1'b0;
	logic [7:0] rd_data = 8'h00, rd_byte = 8'h00, rx_bits = 8'h00;
	logic rd_take;
	int n_bits = 0;
	logic cs_n, sck, mosi, si_out, si_oe_n, so_out, so_oe_n, evt_valid;
	flash_frontend_pkg::frame_event_s evt, e, exp_q[$];
	int n_fail = 0, checks_done = 0, cycles = 0;
	always #20 clk = ~clk;
	spi_host_model host (.clk(clk), .cs_n(cs_n), .sck(sck), .mosi(mosi));
	// Pin levels resolved from the device's enables
	serial_flash_command_frontend dut (.CLK(clk), .RESET_N(reset_n), .CS_N_IN(cs_n),
		.SCK_IN(sck), .INPUT_PIN_DUAL_OUTPUT_IN(si_oe_n ? mosi : si_out),
		.INPUT_PIN_DUAL_OUTPUT_OUT(si_out), .INPUT_PIN_DUAL_OUTPUT_OE_N(si_oe_n),
		.OUTPUT_PIN_DUAL_INPUT_IN(so_oe_n ? ~mosi : so_out),
		.OUTPUT_PIN_DUAL_INPUT_OUT(so_out), .OUTPUT_PIN_DUAL_INPUT_OE_N(so_oe_n),
		.BUSY(busy), .STANDBY(), .FRAME_ACTIVE(), .OVERRUN(), .EVT_VALID(evt_valid),
		.EVT_READY(evt_ready), .EVT(evt), .RD_DATA(rd_data), .RD_TAKE(rd_take));
	// Byte the device loaded for output, kept until the host has shifted it in
	always @(posedge clk) if (rd_take === 1'b1) rd_byte <= rd_data;
	// Host side of a read: sample the output pin on each rise while it is driven
	always @(posedge sck) if (so_oe_n === 1'b0) begin
		rx_bits = {rx_bits[6:0], so_out};
		n_bits++;
		if (n_bits % 8 == 0) check("read data", rx_bits, rd_byte);
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Expected event; region mask worked out here from the opcode
	task automatic note(input flash_frontend_pkg::event_tag_e t, input logic [7:0] op,
		input logic [23:0] a, input logic [7:0] d);
		logic [19:0] m;
		m = op == 8'h02 ? 20'hF_FF00 : op == 8'h20 ? 20'hF_F000 : op == 8'h52 ? 20'hF_8000 :
			op == 8'h03 ? 20'hF_FFFF : 20'hF_0000;
		exp_q.push_back('{t, op, flash_frontend_pkg::K_NONE, a[19:0], a[19:0] & m, a[19:16], d});
	endtask
	task automatic drain(input string name);
		for (int i = 0; i < 300 && exp_q.size() > 0; i++) @(posedge clk);
		check("events left", exp_q.size(), 0);
		check("pins released", {so_oe_n, si_oe_n}, 2'b11);
		$display("test %s done", name);
	endtask
	task automatic stop_test();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Random stalls by the consumer and random engine activity
	always @(posedge clk) begin
		evt_ready <= 1'($urandom_range(0, 1));
		busy <= 1'($urandom_range(0, 1));
		rd_data <= 8'($urandom());
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			stop_test();
		end
	end
	// Each event taken from the buffer is matched against the oldest note
	always @(posedge clk) if (evt_valid === 1'b1 && evt_ready) begin
		if (exp_q.size() == 0) begin
			check("unexpected event", 1, 0);
		end else begin
			e = exp_q.pop_front();
			check("tag", evt.tag, e.tag);
			if (e.tag == flash_frontend_pkg::EV_CMD) begin
				check("opcode", evt.opcode, e.opcode);
				check("addr", evt.addr, e.addr);
				check("region", evt.region, e.region);
				check("sector", evt.sector, e.sector);
			end
			if (e.tag == flash_frontend_pkg::EV_DATA) check("data", evt.data, e.data);
		end
	end
	initial begin
		logic [23:0] a;
		logic [7:0] d, ops[3];
		ops = '{8'h20, 8'h52, 8'hD8};
		void'($urandom(32'h6433));
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		// Program and erase with junk in the top nibble, modes alternating
		for (int k = 0; k < 6; k++) begin
			a = 24'($urandom());
			d = k < 3 ? 8'h02 : ops[k-3];
			note(flash_frontend_pkg::EV_CMD, d, a, 8'h00);
			if (k < 3) note(flash_frontend_pkg::EV_DATA, d, a, a[7:0] ^ 8'hA5);
			note(flash_frontend_pkg::EV_END, d, a, 8'h00);
			host.frame('{d, a[23:16], a[15:8], a[7:0], a[7:0] ^ 8'hA5}, k < 3 ? 40 : 32, k[0]);
		end
		drain("program and erase");
		// Single-lane read of one byte in each clock mode
		for (int k = 0; k < 2; k++) begin
			a = 24'($urandom());
			note(flash_frontend_pkg::EV_CMD, 8'h03, a, 8'h00);
			note(flash_frontend_pkg::EV_END, 8'h03, a, 8'h00);
			host.frame('{8'h03, a[23:16], a[15:8], a[7:0], 8'h00}, 40, k[0]);
		end
		drain("read");
		check("read bits", n_bits, 16);
		// Unknown opcode followed by a valid-looking command body
		host.frame('{8'hFF, 8'h02, 8'h01, 8'h02, 8'h03, 8'h04}, 48, 1'b0);
		drain("unsupported opcode");
		// Frames cut short inside opcode and inside the address
		for (int n = 5; n < 32; n += 13) host.frame('{8'h02, 8'h0F, 8'h12, 8'h34}, n, n[1]);
		drain("short frames");
		stop_test();
	end
endmodule
`default_nettype wire

// ### tb/spi_host_model.sv
// Purpose: Host end of the serial link, clock mode 0 or 3, single lane.
// Assumes: Half period of four CLK cycles, so one bit takes 320 ns.
// Notes:   The data line shows the inverse of its last bit between frames.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	// Bench clock
	input wire logic clk,
	// Link pins
	output logic cs_n,
	output logic sck,
	output logic mosi
);
	// Deselected and quiet at time zero
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		mosi = 1'b0;
	end
	// One frame, bytes MSB first; nbits below the full count cuts it short
	task automatic frame(input logic [7:0] b[$], input int nbits, input logic idle);
		sck <= idle; // Idle level picks mode 0 or mode 3
		repeat (4) @(posedge clk);
		cs_n <= 1'b0;
		for (int i = 0; i < nbits; i++) begin
			repeat (4) @(posedge clk);
			sck <= 1'b0;
			mosi <= b[i/8][7-i%8];
			repeat (4) @(posedge clk);
			sck <= 1'b1; // Device takes the bit on this rise
		end
		repeat (4) @(posedge clk);
		sck <= idle;
		mosi <= ~mosi; // A released line must not look held
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ### verilog/event_buffer.sv
// Purpose: Small FIFO between the frame decoder and the array engine.
// Assumes: Single clock; writes are dropped inside the buffer when IN_READY is low.
// Notes:   Depth two covers one stalled word plus one in flight.
`timescale 1ns/1ps
`default_nettype none
module event_buffer #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 2
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// Fill side
	input wire logic IN_VALID,
	output logic IN_READY,
	input wire logic [WIDTH-1:0] IN_DATA,
	// Drain side
	output logic OUT_VALID,
	input wire logic OUT_READY,
	output logic [WIDTH-1:0] OUT_DATA
);
	localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CNT_W = $clog2(DEPTH + 1);
	localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
	localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
	logic [CNT_W-1:0] count_q;
	logic do_wr, do_rd;

	// Honest flags straight from the fill count
	assign IN_READY = (count_q != FULL);
	assign OUT_VALID = (count_q != '0);
	assign OUT_DATA = mem[rd_ptr_q];
	assign do_wr = IN_VALID && IN_READY;
	assign do_rd = OUT_VALID && OUT_READY;

	// Storage; no reset needed since reads are gated by the count
	always_ff @(posedge CLK) begin
		if (do_wr) begin
			mem[wr_ptr_q] <= IN_DATA;
		end
	end

	// Pointers and fill count
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_q <= (wr_ptr_q == LAST) ? '0 : wr_ptr_q + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_q <= (rd_ptr_q == LAST) ? '0 : rd_ptr_q + 1'b1;
			end
			if (do_wr && !do_rd) begin
				count_q <= count_q + 1'b1;
			end else if (do_rd && !do_wr) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// ### verilog/flash_frontend_pkg.sv
// Purpose: Shared types, opcodes, address map constants and decode helpers
//          for the serial flash command front end.
// Assumes: 24-bit address on the link, 20-bit array, MSB first.
// Notes:   Opcode values and byte counts follow the command table.
package flash_frontend_pkg;

	// Link framing
	localparam int unsigned BITS_PER_BYTE = 8;
	localparam logic [1:0] ADDR_BYTES = 2'h3;
	localparam int unsigned LINK_ADDR_W = 24;
	localparam int unsigned ARRAY_ADDR_W = 20;
	localparam logic [19:0] ARRAY_TOP = 20'hF_FFFF;

	// Region sizes as counts of discarded low address bits
	localparam int unsigned PAGE_BITS = 8;
	localparam int unsigned BLOCK_4K_BITS = 12;
	localparam int unsigned BLOCK_32K_BITS = 15;
	localparam int unsigned BLOCK_64K_BITS = 16;
	localparam int unsigned SECTOR_BITS = 16;

	// Supported opcodes
	localparam logic [7:0] OP_READ_FAST2 = 8'h1B;
	localparam logic [7:0] OP_READ_FAST = 8'h0B;
	localparam logic [7:0] OP_READ_SLOW = 8'h03;
	localparam logic [7:0] OP_READ_DUAL = 8'h3B;
	localparam logic [7:0] OP_ERASE_4K = 8'h20;
	localparam logic [7:0] OP_ERASE_32K = 8'h52;
	localparam logic [7:0] OP_ERASE_64K = 8'hD8;
	localparam logic [7:0] OP_ERASE_CHIP_A = 8'h60;
	localparam logic [7:0] OP_ERASE_CHIP_B = 8'hC7;
	localparam logic [7:0] OP_PROGRAM = 8'h02;
	localparam logic [7:0] OP_PROGRAM_DUAL = 8'hA2;
	localparam logic [7:0] OP_PROTECT = 8'h36;
	localparam logic [7:0] OP_UNPROTECT = 8'h39;
	localparam logic [7:0] OP_READ_PROT = 8'h3C;
	localparam logic [7:0] OP_LOCKDOWN = 8'h33;
	localparam logic [7:0] OP_FREEZE_LOCK = 8'h34;
	localparam logic [7:0] OP_READ_LOCK = 8'h35;
	localparam logic [7:0] OP_OTP_PROGRAM = 8'h9B;
	localparam logic [7:0] OP_OTP_READ = 8'h77;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_OPCODE = 3'h1,
		ST_ADDR = 3'h3,
		ST_DUMMY = 3'h2,
		ST_DATA = 3'h6,
		ST_IGNORE = 3'h7
	} frame_state_e;

	typedef enum logic [3:0] {
		K_NONE, K_READ, K_READ_DUAL, K_ERASE_4K, K_ERASE_32K, K_ERASE_64K, K_ERASE_CHIP,
		K_PROGRAM, K_PROGRAM_DUAL, K_PROTECT, K_UNPROTECT, K_SECTOR_REG, K_OTHER
	} cmd_kind_e;

	typedef enum logic [1:0] {DIR_NONE, DIR_IN, DIR_OUT} data_dir_e;

	typedef enum logic [1:0] {EV_CMD, EV_DATA, EV_END} event_tag_e;

	typedef struct packed {
		logic supported;
		cmd_kind_e kind;
		logic [1:0] addr_bytes;
		logic [1:0] dummy_bytes;
		data_dir_e dir;
		logic dual;
	} cmd_info_s;

	typedef struct packed {
		event_tag_e tag;
		logic [7:0] opcode;
		cmd_kind_e kind;
		logic [19:0] addr;
		logic [19:0] region;
		logic [3:0] sector;
		logic [7:0] data;
	} frame_event_s;

	// Opcode table: byte counts that follow each supported opcode
	function automatic cmd_info_s decode_cmd(input logic [7:0] op);
		cmd_info_s r;
		r = '{1'b1, K_OTHER, ADDR_BYTES, 2'h0, DIR_NONE, 1'b0};
		unique case (op)
			OP_READ_FAST2: r = '{1'b1, K_READ, ADDR_BYTES, 2'h2, DIR_OUT, 1'b0};
			OP_READ_FAST: r = '{1'b1, K_READ, ADDR_BYTES, 2'h1, DIR_OUT, 1'b0};
			OP_READ_SLOW: r = '{1'b1, K_READ, ADDR_BYTES, 2'h0, DIR_OUT, 1'b0};
			OP_READ_DUAL: r = '{1'b1, K_READ_DUAL, ADDR_BYTES, 2'h1, DIR_OUT, 1'b1};
			OP_ERASE_4K: r.kind = K_ERASE_4K;
			OP_ERASE_32K: r.kind = K_ERASE_32K;
			OP_ERASE_64K: r.kind = K_ERASE_64K;
			OP_ERASE_CHIP_A, OP_ERASE_CHIP_B: r = '{1'b1, K_ERASE_CHIP, 2'h0, 2'h0, DIR_NONE, 1'b0};
			OP_PROGRAM: r = '{1'b1, K_PROGRAM, ADDR_BYTES, 2'h0, DIR_IN, 1'b0};
			OP_PROGRAM_DUAL: r = '{1'b1, K_PROGRAM_DUAL, ADDR_BYTES, 2'h0, DIR_IN, 1'b1};
			OP_PROTECT: r.kind = K_PROTECT;
			OP_UNPROTECT: r.kind = K_UNPROTECT;
			OP_READ_PROT, OP_READ_LOCK: r = '{1'b1, K_SECTOR_REG, ADDR_BYTES, 2'h0, DIR_OUT, 1'b0};
			OP_LOCKDOWN, OP_FREEZE_LOCK: r = '{1'b1, K_SECTOR_REG, ADDR_BYTES, 2'h0, DIR_IN, 1'b0};
			OP_OTP_PROGRAM: r = '{1'b1, K_OTHER, ADDR_BYTES, 2'h0, DIR_IN, 1'b0};
			OP_OTP_READ: r = '{1'b1, K_OTHER, ADDR_BYTES, 2'h2, DIR_OUT, 1'b0};
			8'h06, 8'h04, 8'hB9, 8'hAB: r = '{1'b1, K_OTHER, 2'h0, 2'h0, DIR_NONE, 1'b0};
			8'h05, 8'h9F: r = '{1'b1, K_OTHER, 2'h0, 2'h0, DIR_OUT, 1'b0};
			8'h01, 8'h31, 8'hF0: r = '{1'b1, K_OTHER, 2'h0, 2'h0, DIR_IN, 1'b0};
			default: r = '{1'b0, K_NONE, 2'h0, 2'h0, DIR_NONE, 1'b0};
		endcase
		return r;
	endfunction

	// Base of the region a command targets: low bits below its size are dropped
	function automatic logic [19:0] region_base(input logic [19:0] a, input cmd_kind_e k);
		logic [19:0] m;
		m = '1;
		unique case (k)
			K_ERASE_4K: m = m << BLOCK_4K_BITS;
			K_ERASE_32K: m = m << BLOCK_32K_BITS;
			K_ERASE_64K, K_PROTECT, K_UNPROTECT, K_SECTOR_REG: m = m << SECTOR_BITS;
			K_PROGRAM, K_PROGRAM_DUAL: m = m << PAGE_BITS;
			K_ERASE_CHIP: m = '0;
			default: m = '1;
		endcase
		return a & m;
	endfunction

endpackage

// ### verilog/serial_flash_command_frontend.sv
// Purpose: Serial bus front end of a serial flash: frames, opcode, address,
//          data in and out, and address decoding onto the array map.
// Assumes: Link pins are asynchronous to CLK and oversampled at least 6x.
// Notes:   Events leave through a two-entry buffer; read data comes in on RD_DATA.
// Operation
// - Works with hosts using clock mode 0 or mode 3 only.
// - Input sampled on clock rising edge; output changes on falling edge.
// - Either clock idle level accepted, same edges used.
// - All bytes travel most significant bit first, both ways.
// - Unsupported opcode starts nothing and changes no state.
// - After unsupported opcode, input ignored until select rises and falls again.
// - Select rising before opcode and address complete performs nothing, back to idle.
// - Address commands send exactly three address bytes, top bit first.
// - Top four address bits ignored; only twenty bits reach the array.
// - Dual program turns output pin into second input, two bits per clock.
// - Dual read turns input pin into second output, two bits per clock.
// - Erase in 4KB, 32KB, 64KB aligned blocks, or whole chip.
// - Opcode picks erase size; address picks the block.
// - Program writes one to 256 bytes inside one page chosen by upper bits.
// - Sixteen 64KB sectors numbered from zero, each protected separately.
// - Deselected: output pin released, input pin ignored.
// - Running program or erase completes; standby only after it ends.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_command_frontend (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// Serial link pins
	input wire logic CS_N_IN,
	input wire logic SCK_IN,
	input wire logic INPUT_PIN_DUAL_OUTPUT_IN,
	output logic INPUT_PIN_DUAL_OUTPUT_OUT,
	output logic INPUT_PIN_DUAL_OUTPUT_OE_N,
	input wire logic OUTPUT_PIN_DUAL_INPUT_IN,
	output logic OUTPUT_PIN_DUAL_INPUT_OUT,
	output logic OUTPUT_PIN_DUAL_INPUT_OE_N,
	// Array engine status
	input wire logic BUSY,
	output logic STANDBY,
	output logic FRAME_ACTIVE,
	output logic OVERRUN,
	// Decoded event stream
	output logic EVT_VALID,
	input wire logic EVT_READY,
	output flash_frontend_pkg::frame_event_s EVT,
	// Read data for the output phase
	input wire logic [7:0] RD_DATA,
	output logic RD_TAKE
);
	flash_frontend_pkg::frame_state_e state_q;
	flash_frontend_pkg::cmd_info_s info_q, info_now;
	flash_frontend_pkg::frame_event_s push_evt;
	logic cs_s1_q, cs_s2_q, cs_prev_q, sck_s1_q, sck_s2_q, sck_prev_q;
	logic si_s1_q, si_s2_q, so_s1_q, so_s2_q;
	logic sck_rise, sck_fall, cs_rise, cs_fall, receiving, byte_done;
	logic dual_in, dual_out, out_active, push_valid, push_ready, cmd_issued_q;
	logic [2:0] bit_cnt_q, step;
	logic [3:0] cnt_sum;
	logic [1:0] byte_cnt_q;
	logic [7:0] rx_sr_q, rx_next, opcode_q, tx_sr_q;
	logic [23:0] addr_q, addr_full;
	logic so_drive_q, sio_drive_q, so_out_q, sio_out_q, overrun_q, standby_q;

	// Assemble an event; the array address keeps only the low twenty bits
	function automatic flash_frontend_pkg::frame_event_s make_event(
		input flash_frontend_pkg::event_tag_e tag, input logic [7:0] op,
		input flash_frontend_pkg::cmd_kind_e kind, input logic [23:0] a,
		input logic [7:0] data);
		flash_frontend_pkg::frame_event_s e;
		logic [19:0] a20;
		a20 = a[19:0];
		e.tag = tag;
		e.opcode = op;
		e.kind = kind;
		e.addr = a20;
		e.region = flash_frontend_pkg::region_base(a20, kind);
		e.sector = a20[19:16];
		e.data = data;
		return e;
	endfunction

	// Two-stage synchronisers for every link pin; third stage only for edges
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_prev_q <= 1'b1;
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
			sck_prev_q <= 1'b0;
			si_s1_q <= 1'b0;
			si_s2_q <= 1'b0;
			so_s1_q <= 1'b0;
			so_s2_q <= 1'b0;
		end else begin
			cs_s1_q <= CS_N_IN;
			cs_s2_q <= cs_s1_q;
			cs_prev_q <= cs_s2_q;
			sck_s1_q <= SCK_IN;
			sck_s2_q <= sck_s1_q;
			sck_prev_q <= sck_s2_q;
			si_s1_q <= INPUT_PIN_DUAL_OUTPUT_IN;
			si_s2_q <= si_s1_q;
			so_s1_q <= OUTPUT_PIN_DUAL_INPUT_IN;
			so_s2_q <= so_s1_q;
		end
	end

	// Edges only: the idle level of the clock never matters
	assign sck_rise = sck_s2_q && !sck_prev_q;
	assign sck_fall = !sck_s2_q && sck_prev_q;
	assign cs_fall = !cs_s2_q && cs_prev_q;
	assign cs_rise = cs_s2_q && !cs_prev_q;

	// Bit timing: single lanes move one bit per edge, dual lanes two
	always_comb begin
		receiving = (state_q != flash_frontend_pkg::ST_IDLE) &&
			(state_q != flash_frontend_pkg::ST_IGNORE) && !cs_s2_q;
		dual_in = (state_q == flash_frontend_pkg::ST_DATA) && info_q.dual &&
			(info_q.dir == flash_frontend_pkg::DIR_IN);
		out_active = (state_q == flash_frontend_pkg::ST_DATA) &&
			(info_q.dir == flash_frontend_pkg::DIR_OUT) && !cs_s2_q;
		dual_out = out_active && info_q.dual;
		step = (dual_in || dual_out) ? 3'h2 : 3'h1;
		cnt_sum = {1'b0, bit_cnt_q} + {1'b0, step};
		byte_done = sck_rise && receiving && cnt_sum[3];
		// Dual input: output pin carries the higher bit of each pair
		rx_next = dual_in ? {rx_sr_q[5:0], so_s2_q, si_s2_q} : {rx_sr_q[6:0], si_s2_q};
		addr_full = {addr_q[15:0], rx_next};
		info_now = flash_frontend_pkg::decode_cmd(rx_next);
	end

	// One event at most per cycle; end-of-frame wins over a late byte
	always_comb begin
		push_valid = 1'b0;
		push_evt = '0;
		if (cs_rise) begin
			push_valid = cmd_issued_q;
			push_evt = make_event(flash_frontend_pkg::EV_END, opcode_q, info_q.kind, addr_q, 8'h00);
		end else if (byte_done) begin
			unique case (state_q)
				flash_frontend_pkg::ST_OPCODE: begin
					push_valid = info_now.supported && (info_now.addr_bytes == 2'h0);
					push_evt = make_event(flash_frontend_pkg::EV_CMD, rx_next, info_now.kind,
						24'h00_0000, 8'h00);
				end
				flash_frontend_pkg::ST_ADDR: begin
					push_valid = (byte_cnt_q == flash_frontend_pkg::ADDR_BYTES - 2'h1) &&
						(info_q.dummy_bytes == 2'h0);
					push_evt = make_event(flash_frontend_pkg::EV_CMD, opcode_q, info_q.kind,
						addr_full, 8'h00);
				end
				flash_frontend_pkg::ST_DUMMY: begin
					push_valid = (byte_cnt_q == info_q.dummy_bytes - 2'h1);
					push_evt = make_event(flash_frontend_pkg::EV_CMD, opcode_q, info_q.kind,
						addr_q, 8'h00);
				end
				flash_frontend_pkg::ST_DATA: begin
					push_valid = (info_q.dir == flash_frontend_pkg::DIR_IN);
					push_evt = make_event(flash_frontend_pkg::EV_DATA, opcode_q, info_q.kind,
						addr_q, rx_next);
				end
				default: begin
					push_valid = 1'b0;
				end
			endcase
		end
	end

	// Frame sequencer; a refused event drops the rest of the frame
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_q <= flash_frontend_pkg::ST_IDLE;
		end else if (cs_rise) begin
			state_q <= flash_frontend_pkg::ST_IDLE;
		end else if (cs_fall) begin
			state_q <= flash_frontend_pkg::ST_OPCODE;
		end else if (push_valid && !push_ready) begin
			state_q <= flash_frontend_pkg::ST_IGNORE;
		end else if (byte_done) begin
			unique case (state_q)
				flash_frontend_pkg::ST_OPCODE: begin
					if (!info_now.supported) begin
						state_q <= flash_frontend_pkg::ST_IGNORE;
					end else if (info_now.addr_bytes != 2'h0) begin
						state_q <= flash_frontend_pkg::ST_ADDR;
					end else begin
						state_q <= flash_frontend_pkg::ST_DATA;
					end
				end
				flash_frontend_pkg::ST_ADDR: begin
					if (byte_cnt_q == flash_frontend_pkg::ADDR_BYTES - 2'h1) begin
						state_q <= (info_q.dummy_bytes != 2'h0) ?
							flash_frontend_pkg::ST_DUMMY : flash_frontend_pkg::ST_DATA;
					end
				end
				flash_frontend_pkg::ST_DUMMY: begin
					if (byte_cnt_q == info_q.dummy_bytes - 2'h1) begin
						state_q <= flash_frontend_pkg::ST_DATA;
					end
				end
				default: begin
					state_q <= state_q;
				end
			endcase
		end
	end

	// Bit and byte counters, restarted at every selection
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			bit_cnt_q <= 3'h0;
			byte_cnt_q <= 2'h0;
		end else if (cs_fall) begin
			bit_cnt_q <= 3'h0;
			byte_cnt_q <= 2'h0;
		end else if (sck_rise && receiving) begin
			bit_cnt_q <= cnt_sum[2:0];
			if (byte_done && state_q != flash_frontend_pkg::ST_OPCODE) begin
				byte_cnt_q <= (state_q == flash_frontend_pkg::ST_ADDR &&
					byte_cnt_q == flash_frontend_pkg::ADDR_BYTES - 2'h1) ? 2'h0 : byte_cnt_q + 2'h1;
			end
		end
	end

	// Shift register, opcode, command attributes and address
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rx_sr_q <= 8'h00;
			opcode_q <= 8'h00;
			info_q <= '0;
			addr_q <= 24'h00_0000;
		end else if (sck_rise && receiving) begin
			rx_sr_q <= rx_next;
			if (byte_done && state_q == flash_frontend_pkg::ST_OPCODE && info_now.supported) begin
				opcode_q <= rx_next;
				info_q <= info_now;
				addr_q <= 24'h00_0000;
			end
			if (byte_done && state_q == flash_frontend_pkg::ST_ADDR) begin
				addr_q <= addr_full;
			end
		end
	end

	// A command is owed its end marker once accepted
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cmd_issued_q <= 1'b0;
		end else if (cs_fall || (cs_rise && push_ready)) begin
			cmd_issued_q <= 1'b0;
		end else if (push_valid && push_ready && push_evt.tag == flash_frontend_pkg::EV_CMD) begin
			cmd_issued_q <= 1'b1;
		end
	end

	// Sticky refusal flag; a refusal in the clearing cycle still sets it
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			overrun_q <= 1'b0;
		end else if (push_valid && !push_ready) begin
			overrun_q <= 1'b1;
		end else if (cs_fall) begin
			overrun_q <= 1'b0;
		end
	end

	// Output shifter changes only on falling edges, MSB first
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			tx_sr_q <= 8'h00;
			so_out_q <= 1'b0;
			sio_out_q <= 1'b0;
		end else if (sck_fall && out_active) begin
			if (bit_cnt_q == 3'h0) begin
				so_out_q <= RD_DATA[7];
				sio_out_q <= dual_out ? RD_DATA[6] : sio_out_q;
				tx_sr_q <= dual_out ? {RD_DATA[5:0], 2'b00} : {RD_DATA[6:0], 1'b0};
			end else begin
				so_out_q <= tx_sr_q[7];
				sio_out_q <= dual_out ? tx_sr_q[6] : sio_out_q;
				tx_sr_q <= dual_out ? {tx_sr_q[5:0], 2'b00} : {tx_sr_q[6:0], 1'b0};
			end
		end
	end

	// Pin drivers; both released while deselected
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			so_drive_q <= 1'b0;
			sio_drive_q <= 1'b0;
		end else begin
			so_drive_q <= out_active;
			sio_drive_q <= dual_out;
		end
	end

	// Standby waits for a running program or erase to finish
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			standby_q <= 1'b0;
		end else begin
			standby_q <= cs_s2_q && !BUSY;
		end
	end

	assign RD_TAKE = sck_fall && out_active && (bit_cnt_q == 3'h0);
	assign OUTPUT_PIN_DUAL_INPUT_OUT = so_out_q;
	assign OUTPUT_PIN_DUAL_INPUT_OE_N = !so_drive_q;
	assign INPUT_PIN_DUAL_OUTPUT_OUT = sio_out_q;
	assign INPUT_PIN_DUAL_OUTPUT_OE_N = !sio_drive_q;
	assign STANDBY = standby_q;
	assign FRAME_ACTIVE = !cs_s2_q;
	assign OVERRUN = overrun_q;

	// Buffer absorbs a short stall by the array engine
	event_buffer #(
		.WIDTH($bits(flash_frontend_pkg::frame_event_s)),
		.DEPTH(2)
	) u_event_buffer (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.IN_VALID(push_valid),
		.IN_READY(push_ready),
		.IN_DATA(push_evt),
		.OUT_VALID(EVT_VALID),
		.OUT_READY(EVT_READY),
		.OUT_DATA(EVT)
	);

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	property p_rx_on_rise;
		$changed(rx_sr_q) |-> $past(sck_rise);
	endproperty
	a_rx_on_rise: assert property (p_rx_on_rise) else $error("shift changed off rise");

	property p_tx_on_fall;
		$changed(so_out_q) |-> $past(sck_fall) && $past(out_active);
	endproperty
	a_tx_on_fall: assert property (p_tx_on_fall) else $error("output changed off fall");

	property p_ignore_holds;
		(state_q == flash_frontend_pkg::ST_IGNORE) && !cs_rise |=>
			state_q == flash_frontend_pkg::ST_IGNORE;
	endproperty
	a_ignore_holds: assert property (p_ignore_holds) else $error("left ignore early");

	property p_ignore_silent;
		(state_q == flash_frontend_pkg::ST_IGNORE) && !cs_rise |-> !push_valid && !RD_TAKE;
	endproperty
	a_ignore_silent: assert property (p_ignore_silent) else $error("event while ignoring");

	property p_bad_opcode;
		byte_done && (state_q == flash_frontend_pkg::ST_OPCODE) && !info_now.supported &&
			!cs_rise && !cs_fall |-> !push_valid ##1 state_q == flash_frontend_pkg::ST_IGNORE;
	endproperty
	a_bad_opcode: assert property (p_bad_opcode) else $error("bad opcode not dropped");

	property p_short_frame;
		cs_rise && !cmd_issued_q |-> !push_valid ##1 state_q == flash_frontend_pkg::ST_IDLE;
	endproperty
	a_short_frame: assert property (p_short_frame) else $error("short frame acted");

	property p_release;
		cs_s2_q && $past(cs_s2_q) |-> OUTPUT_PIN_DUAL_INPUT_OE_N && INPUT_PIN_DUAL_OUTPUT_OE_N;
	endproperty
	a_release: assert property (p_release) else $error("pin driven while deselected");

	property p_sio_dual_only;
		!INPUT_PIN_DUAL_OUTPUT_OE_N |-> info_q.dual && (info_q.dir == flash_frontend_pkg::DIR_OUT);
	endproperty
	a_sio_dual_only: assert property (p_sio_dual_only) else $error("input pin driven");

	property p_region_4k;
		push_valid && push_evt.tag == flash_frontend_pkg::EV_CMD &&
			push_evt.kind == flash_frontend_pkg::K_ERASE_4K |->
			push_evt.region == {push_evt.addr[19:12], 12'h000};
	endproperty
	a_region_4k: assert property (p_region_4k) else $error("4KB base wrong");

	property p_sector;
		push_valid |-> push_evt.sector == push_evt.addr[19:16];
	endproperty
	a_sector: assert property (p_sector) else $error("sector number wrong");

	property p_standby_busy;
		BUSY |=> !STANDBY;
	endproperty
	a_standby_busy: assert property (p_standby_busy) else $error("standby while busy");

	property p_eight_bits;
		(state_q == flash_frontend_pkg::ST_OPCODE) && sck_rise && (bit_cnt_q != 3'h7) &&
			!cs_rise |=> state_q == flash_frontend_pkg::ST_OPCODE;
	endproperty
	a_eight_bits: assert property (p_eight_bits) else $error("opcode left early");

	c_erase: cover property (push_valid && push_evt.kind == flash_frontend_pkg::K_ERASE_64K);
	c_dual_read: cover property (RD_TAKE && dual_out);
	c_dual_prog: cover property (push_valid && push_evt.tag == flash_frontend_pkg::EV_DATA && dual_in);
	c_refused: cover property (push_valid && !push_ready);

endmodule
`default_nettype wire
